//--- dci_pkg.sv
// Package for the data clock input control block: map, fields, timing, types
package dci_pkg;
    localparam logic [6:0] DCI_CTRL_ADDR = 7'h03;
    localparam logic [7:0] DCI_CTRL_RESET = 8'h00;
    localparam int DCI_EN_BIT = 0;
    localparam int DCI_OK_BIT = 1;
    localparam int DCI_Q_BIT = 2;
    localparam int DCI_TADJ_LSB = 4;
    localparam int DCI_TADJ_MSB = 6;
    localparam logic [2:0] DCI_TADJ_M2 = 3'h6;
    localparam logic [2:0] DCI_TADJ_M1 = 3'h7;
    localparam logic [2:0] DCI_TADJ_DEF = 3'h0;
    localparam logic [2:0] DCI_TADJ_P1 = 3'h1;
    localparam logic [2:0] DCI_TADJ_P2 = 3'h2;
    localparam logic [9:0] DCI_DLY_QUAD_PS = 10'h000;
    localparam logic [9:0] DCI_DLY_M2_PS = 10'h0E6;
    localparam logic [9:0] DCI_DLY_M1_PS = 10'h13B;
    localparam logic [9:0] DCI_DLY_DEF_PS = 10'h190;
    localparam logic [9:0] DCI_DLY_P1_PS = 10'h1E5;
    localparam logic [9:0] DCI_DLY_P2_PS = 10'h23A;
    localparam logic [9:0] DCI_DLY_STEP_PS = 10'h055;
    localparam int DCI_MIN_FREQ_KHZ = 25000;
    localparam int DCI_SYS_KHZ = 100000;
    localparam int DCI_PRESCALE = 16;
    localparam int DCI_WINDOW_CYC = 1280;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } dci_reg_req_type;

    typedef struct packed {
        logic [2:0] tadj;
        logic quad;
        logic enable;
    } dci_ctrl_type;

    typedef struct packed {
        logic rx_enable;
        logic quad;
        logic [2:0] tadj;
        logic [9:0] delay_ps;
        logic delay_reserved;
        logic force_midscale;
        logic datapath_reset;
    } dci_clk_ctl_type;
endpackage

//--- dci_clk_detect.sv
// Data clock presence detector spanning link and system clock domains
`timescale 1ns/10ps
module dci_clk_detect #(
    parameter int PRESCALE = 16,
    parameter int WINDOW_CYC = 1280,
    parameter int MIN_TRANS = 20
) (
    // System side
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rx_enable,
    output logic present,
    // Link side
    input wire logic clk_link
);
    import dci_pkg::*;
    localparam int PW = $clog2(PRESCALE);

    if (PRESCALE < 2 || (PRESCALE & (PRESCALE - 1)) != 0)
    begin : g_chk_pre
        $error("PRESCALE must be a power of two");
    end
    // Window and transition counters are 16 bits wide
    if (WINDOW_CYC < 4 || WINDOW_CYC > 65535 || MIN_TRANS > 65534)
    begin : g_chk_win
        $error("Detector window out of range");
    end

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic en_meta;
        logic en_sync;
        logic [PW-1:0] pre;
        logic tog;
    } dci_link_st_type;

    typedef struct packed {
        logic tog_meta;
        logic tog_sync;
        logic tog_last;
        logic [15:0] win;
        logic [15:0] trans;
        logic present;
    } dci_sys_st_type;

    dci_link_st_type l_q, l_d;
    dci_sys_st_type s_q, s_d;

    // Link domain: divided toggle so fast clocks survive sampling at 100MHz
    always_comb
    begin
        l_d = l_q;
        l_d.rst_meta = 1'b1;
        l_d.rst_sync = l_q.rst_meta;
        l_d.en_meta = rx_enable;
        l_d.en_sync = l_q.en_meta;
        if (l_q.rst_sync && l_q.en_sync)
        begin
            l_d.pre = l_q.pre + PW'(1);
            if (l_q.pre == '1)
                l_d.tog = ~l_q.tog;
        end
    end

    always_ff @(posedge clk_link or negedge rst_n)
    begin
        if (!rst_n)
            l_q <= '0;
        else
            l_q <= l_d;
    end

    // System domain: count toggle transitions in a fixed window
    always_comb
    begin
        s_d = s_q;
        s_d.tog_meta = l_q.tog;
        s_d.tog_sync = s_q.tog_meta;
        s_d.tog_last = s_q.tog_sync;
        if (s_q.tog_sync != s_q.tog_last)
            s_d.trans = s_q.trans + 16'h0001;
        if (s_q.win == 16'(WINDOW_CYC - 1))
        begin
            s_d.win = 16'h0000;
            s_d.trans = 16'h0000;
            s_d.present = (s_q.trans > 16'(MIN_TRANS));
        end
        else
            s_d.win = s_q.win + 16'h0001;
        if (!rx_enable)
        begin
            s_d.present = 1'b0;
            s_d.win = 16'h0000;
            s_d.trans = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign present = s_q.present;
endmodule

//--- dci_clock_ctrl.sv
// Data clock input control register, delay select and presence gating
`timescale 1ns/10ps
module dci_clock_ctrl #(
    parameter int DET_MIN_KHZ = dci_pkg::DCI_MIN_FREQ_KHZ,
    parameter int WINDOW_CYC = dci_pkg::DCI_WINDOW_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access port
    input dci_pkg::dci_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    // DDR data clock input, link domain
    input wire logic ddr_data_clock_input,
    // Clock path control and status
    output dci_pkg::dci_clk_ctl_type clk_ctl,
    output logic data_clock_present_flag
);
    import dci_pkg::*;

    localparam int MIN_TRANS =
        (DET_MIN_KHZ * WINDOW_CYC) / (DCI_SYS_KHZ * DCI_PRESCALE);

    if (DET_MIN_KHZ < 1 || MIN_TRANS < 1)
    begin : g_chk_thr
        $error("Detector threshold too low for window");
    end

    typedef struct packed {
        dci_ctrl_type ctrl;
        logic flag;
        logic [7:0] rdata;
        dci_clk_ctl_type out;
        logic up;
    } dci_st_type;

    dci_st_type q, d;
    logic det_present;
    logic ctrl_hit;

    dci_clk_detect #(
        .PRESCALE(DCI_PRESCALE),
        .WINDOW_CYC(WINDOW_CYC),
        .MIN_TRANS(MIN_TRANS)
    ) u_detect (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rx_enable(q.ctrl.enable),
        .present(det_present),
        .clk_link(ddr_data_clock_input)
    );

    // Only five codes have a defined in-phase delay; others report the default
    function automatic logic [10:0] dly_lookup(input logic quad,
                                               input logic [2:0] tadj);
        logic [10:0] r;
        r = {1'b0, DCI_DLY_DEF_PS};
        if (quad)
            r = {1'b0, DCI_DLY_QUAD_PS};
        else
        begin
            case (tadj)
                DCI_TADJ_M2: r = {1'b0, DCI_DLY_M2_PS};
                DCI_TADJ_M1: r = {1'b0, DCI_DLY_M1_PS};
                DCI_TADJ_DEF: r = {1'b0, DCI_DLY_DEF_PS};
                DCI_TADJ_P1: r = {1'b0, DCI_DLY_P1_PS};
                DCI_TADJ_P2: r = {1'b0, DCI_DLY_P2_PS};
                default: r = {1'b1, DCI_DLY_DEF_PS};
            endcase
        end
        return r;
    endfunction

    assign ctrl_hit = (reg_req.addr == DCI_CTRL_ADDR);

    always_comb
    begin
        logic [10:0] dly;
        dly = 11'h000;
        d = q;
        d.up = 1'b1;
        if (reg_req.wr && ctrl_hit)
        begin
            // Bit 1 is not stored; the flag has a single source
            d.ctrl.enable = reg_req.wdata[DCI_EN_BIT];
            d.ctrl.quad = reg_req.wdata[DCI_Q_BIT];
            d.ctrl.tadj = reg_req.wdata[DCI_TADJ_MSB:DCI_TADJ_LSB];
        end
        d.flag = det_present && q.ctrl.enable;
        if (reg_req.rd)
        begin
            d.rdata = 8'h00;
            if (ctrl_hit)
            begin
                d.rdata[DCI_EN_BIT] = q.ctrl.enable;
                d.rdata[DCI_OK_BIT] = q.flag;
                d.rdata[DCI_Q_BIT] = q.ctrl.quad;
                d.rdata[DCI_TADJ_MSB:DCI_TADJ_LSB] = q.ctrl.tadj;
            end
        end
        dly = dly_lookup(q.ctrl.quad, q.ctrl.tadj);
        d.out.rx_enable = q.ctrl.enable;
        d.out.quad = q.ctrl.quad;
        d.out.tadj = q.ctrl.tadj;
        d.out.delay_ps = dly[9:0];
        d.out.delay_reserved = dly[10];
        d.out.force_midscale = !d.flag;
        d.out.datapath_reset = !d.flag;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.ctrl <= dci_ctrl_type'({DCI_CTRL_RESET[6:4],
                                      DCI_CTRL_RESET[2],
                                      DCI_CTRL_RESET[0]});
            q.rdata <= 8'h00;
            q.out.delay_ps <= DCI_DLY_DEF_PS;
            q.out.force_midscale <= 1'b1;
            q.out.datapath_reset <= 1'b1;
        end
        else
            q <= d;
    end

    assign reg_rdata = q.rdata;
    assign clk_ctl = q.out;
    assign data_clock_present_flag = q.flag;

    // Checks
    a_reset_value: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.up |-> q.ctrl == dci_ctrl_type'(5'h00))
        else $error("Control register not at reset value");

    a_enable_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req.wr && ctrl_hit
            |=> ##1 clk_ctl.rx_enable == $past(reg_req.wdata[0], 2))
        else $error("Receiver enable does not follow write");

    a_flag_off: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.ctrl.enable |=> !data_clock_present_flag)
        else $error("Present flag set with receiver off");

    a_midscale_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !data_clock_present_flag |-> clk_ctl.force_midscale
            && clk_ctl.datapath_reset)
        else $error("Output not forced while clock absent");

    a_flag_readback: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req.rd && ctrl_hit |=> reg_rdata[1] == $past(q.flag))
        else $error("Flag readback differs from detector");

    a_flag_ro: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req.wr && ctrl_hit && reg_req.wdata[1] && !det_present
            |=> !data_clock_present_flag)
        else $error("Write changed present flag");

    a_quad_delay: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        q.ctrl.quad |=> clk_ctl.delay_ps == DCI_DLY_QUAD_PS)
        else $error("Quadrature delay not matched");

    a_default_delay: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.ctrl.quad && q.ctrl.tadj == 3'h0 |=> clk_ctl.delay_ps == 10'h190)
        else $error("Default delay not 400ps");

    a_delay_step: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.ctrl.quad && q.ctrl.tadj == 3'h1
            |=> clk_ctl.delay_ps == 10'h190 + DCI_DLY_STEP_PS)
        else $error("Delay step not 85ps");

    a_reserved_code: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req.wr && ctrl_hit ##1 reg_req.rd && ctrl_hit
            |=> reg_rdata[6:4] == $past(reg_req.wdata[6:4], 2))
        else $error("Delay code not read back as written");

    a_quad_write: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req.wr && ctrl_hit
            |=> ##1 clk_ctl.quad == $past(reg_req.wdata[2], 2))
        else $error("Quadrature select does not follow write");

    a_flag_needs_clock: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !det_present |=> !data_clock_present_flag)
        else $error("Present flag set without detected clock");

    a_delay_short: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.ctrl.quad && q.ctrl.tadj == 3'h6 |=> clk_ctl.delay_ps == 10'h0E6)
        else $error("Delay for code 110 not 230ps");

    a_delay_long: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.ctrl.quad && q.ctrl.tadj == 3'h2 |=> clk_ctl.delay_ps == 10'h23A)
        else $error("Delay for code 010 not 570ps");

    // Reserved codes are flagged so a user can tell the delay is a guess
    a_reserved_flag: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !q.ctrl.quad && q.ctrl.tadj inside {3'h3, 3'h4, 3'h5}
            |=> clk_ctl.delay_reserved)
        else $error("Reserved delay code not marked");

    c_clock_seen: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(data_clock_present_flag));
    c_clock_lost: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(data_clock_present_flag));
    c_quad_mode: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_ctl.quad && data_clock_present_flag);
    c_reserved: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_ctl.delay_reserved);
    c_write_read: cover property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_req.wr && ctrl_hit ##1 reg_req.rd && ctrl_hit);
endmodule

//--- dci_host_clk.sv
// Host-side model driving the DDR data clock into the block
`timescale 1ns/10ps
module dci_host_clk (
    // Control from the bench
    input wire logic run,
    // Clock toward the device
    output logic ddr_data_clock_input
);
    // 8MHz clock, phase offset so it never lines up with clk_sys
    initial
    begin
        ddr_data_clock_input = 1'b0;
        #3.1;
        forever
        begin
            #62.5;
            // Stands still low between bursts, as a stopped host would
            if (run)
                ddr_data_clock_input = ~ddr_data_clock_input;
            else
                ddr_data_clock_input = 1'b0;
        end
    end
    // No data ports modelled, so alignment choice is free
    // No data is sent, so no settle wait is needed
endmodule

//--- tb_data_clock_input_control.sv
// Testbench for the data clock input control block
`timescale 1ns/10ps
module tb_data_clock_input_control;
    import dci_pkg::*;
    logic clk_sys;
    logic rst_n;
    dci_reg_req_type reg_req;
    logic [7:0] reg_rdata;
    logic link_run;
    logic ddr_data_clock_input;
    dci_clk_ctl_type clk_ctl;
    logic data_clock_present_flag;
    int bad_count;
    int num_checks;

    // Lower threshold so the 8MHz bench clock counts as present
    dci_clock_ctrl #(.DET_MIN_KHZ(4000), .WINDOW_CYC(1280)) i_dci_clock_ctrl (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .ddr_data_clock_input(ddr_data_clock_input),
        .clk_ctl(clk_ctl),
        .data_clock_present_flag(data_clock_present_flag)
    );

    dci_host_clk i_dci_host_clk (
        .run(link_run),
        .ddr_data_clock_input(ddr_data_clock_input)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b0;
        // Outputs follow one cycle after the store
        @(posedge clk_sys);
        #1;
    endtask

    task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(posedge clk_sys);
        #1;
        reg_req.rd = 1'b0;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask

    task automatic reg_wr_rd(input logic [6:0] a, input logic [7:0] w,
                             output logic [7:0] d);
        // Read taken on the edge right after the write
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = w;
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_req.rd = 1'b0;
        d = reg_rdata;
    endtask

    task automatic wait_flag(input logic v);
        int n;
        n = 0;
        // Detector needs up to two windows; bound well beyond that
        while (data_clock_present_flag !== v && n < 4000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic t_reset;
        logic [7:0] d;
        reg_rd(DCI_CTRL_ADDR, d);
        chk("control after reset", 16'(d), 16'h0000);
        chk("receiver enable", 16'(clk_ctl.rx_enable), 16'h0000);
        chk("default delay", 16'(clk_ctl.delay_ps), 16'h0190);
        chk("midscale force", 16'(clk_ctl.force_midscale), 16'h0001);
        chk("path reset", 16'(clk_ctl.datapath_reset), 16'h0001);
    endtask

    task automatic t_codes;
        logic [7:0] d;
        logic [2:0] c;
        int s;
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            s = (i >= 6) ? i - 8 : i;
            // Flag, bit 3 and bit 7 written high must not stick
            reg_wr_rd(DCI_CTRL_ADDR, {1'b1, c, 4'hB}, d);
            chk("readback", 16'(d), 16'({1'b0, c, 4'h1}));
            chk("receiver on", 16'(clk_ctl.rx_enable), 16'h0001);
            chk("code", 16'(clk_ctl.tadj), 16'(c));
            chk("reserved", 16'(clk_ctl.delay_reserved),
                16'(i inside {3, 4, 5}));
            if (!(i inside {3, 4, 5}))
                chk("in-phase delay", 16'(clk_ctl.delay_ps),
                    16'(400 + 85 * s));
            reg_wr(DCI_CTRL_ADDR, {1'b0, c, 4'h4});
            chk("quad select", 16'(clk_ctl.quad), 16'h0001);
            chk("quad delay", 16'(clk_ctl.delay_ps), 16'h0000);
        end
    endtask

    task automatic t_unmapped;
        logic [7:0] d;
        reg_wr(7'h04, 8'h77);
        reg_rd(7'h04, d);
        chk("unmapped read", 16'(d), 16'h0000);
        reg_rd(DCI_CTRL_ADDR, d);
        chk("control kept", 16'(d), 16'h0074);
    endtask

    task automatic t_presence;
        logic [7:0] d;
        reg_wr(DCI_CTRL_ADDR, 8'h01);
        link_run = 1'b1;
        wait_flag(1'b1);
        chk("flag set", 16'(data_clock_present_flag), 16'h0001);
        chk("midscale off", 16'(clk_ctl.force_midscale), 16'h0000);
        chk("path running", 16'(clk_ctl.datapath_reset), 16'h0000);
        reg_rd(DCI_CTRL_ADDR, d);
        chk("flag readback", 16'(d), 16'h0003);
        reg_wr(DCI_CTRL_ADDR, 8'h05);
        chk("quad with clock", 16'(clk_ctl.quad), 16'h0001);
        chk("quad delay on", 16'(clk_ctl.delay_ps), 16'h0000);
        chk("flag kept", 16'(data_clock_present_flag), 16'h0001);
        link_run = 1'b0;
        wait_flag(1'b0);
        chk("flag cleared", 16'(data_clock_present_flag), 16'h0000);
        chk("midscale back", 16'(clk_ctl.force_midscale), 16'h0001);
        link_run = 1'b1;
        wait_flag(1'b1);
        chk("flag back", 16'(data_clock_present_flag), 16'h0001);
        reg_wr(DCI_CTRL_ADDR, 8'h00);
        @(posedge clk_sys);
        #1;
        chk("flag off", 16'(data_clock_present_flag), 16'h0000);
        link_run = 1'b0;
    endtask

    initial
    begin
        #500000;
        bad_count++;
        give_verdict();
    end

    initial
    begin
        bad_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        reg_req = '0;
        link_run = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_codes();
        t_unmapped();
        t_presence();
        give_verdict();
    end
endmodule
